// >>> logic/pfac_pkg.sv
`default_nettype none
// shared constants for the fault and alert configuration bank
package pfac_pkg;
  // command codes of the four configuration commands
  localparam logic [7:0]  CMD_VOUT_FAULT_QUALIFY = 8'hd8;
  localparam logic [7:0]  CMD_EXT_TEMP_SCALE     = 8'hd9;
  localparam logic [7:0]  CMD_EXT_TEMP_OFFSET    = 8'hda;
  localparam logic [7:0]  CMD_ALERT_TRIGGER_MASK = 8'hdb;
  // byte counts of each transfer type
  localparam logic [3:0]  LEN_BYTE               = 4'h1;
  localparam logic [3:0]  LEN_WORD               = 4'h2;
  localparam logic [3:0]  LEN_BLOCK              = 4'h7;
  // fields of the qualify byte
  localparam int          QUAL_COUNT_LSB         = 0;
  localparam int          QUAL_COUNT_W           = 4;
  localparam int          QUAL_CROWBAR_BIT       = 7;
  // alert mask bit positions (byte * 8 + bit)
  localparam int          MASK_BYTES             = 7;
  localparam int          MASK_W                 = 56;
  localparam int          MBIT_PHASE_INIT        = 55;
  localparam int          MBIT_GROUP_COMM        = 54;
  localparam int          MBIT_AUX_UV_WARN       = 53;
  localparam int          MBIT_AUX_OV_WARN       = 52;
  localparam int          MBIT_SW_PERIOD         = 51;
  localparam int          MBIT_GROUP_RAIL        = 50;
  localparam int          MBIT_AUX_UV_FAULT      = 49;
  localparam int          MBIT_AUX_OV_FAULT      = 48;
  localparam int          MBIT_BAD_CMD           = 39;
  // reset values
  localparam logic [7:0]  RST_QUALIFY            = 8'h00;
  localparam logic [15:0] RST_SCALE              = 16'h0001;
  localparam logic [15:0] RST_OFFSET             = 16'h0000;
  localparam logic [55:0] RST_MASK               = 56'h00_0000_0000_0000;
  // aux monitor warning thresholds in percent
  localparam logic [7:0]  PCT_FULL               = 8'h64;
  localparam logic [7:0]  PCT_UV_WARN            = 8'h6e;
  localparam logic [7:0]  PCT_OV_WARN            = 8'h5f;
  // divider
  localparam int          DIV_W                  = 16;
  localparam logic [15:0] DIV_ZERO_RESULT        = 16'hffff;
endpackage : pfac_pkg
`default_nettype wire

// >>> logic/pfac_div.sv
`timescale 1ns/1ps
`default_nettype none
// serial restoring divider, one quotient bit per enabled cycle
module pfac_div (
  input  wire logic                        clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        ce_in,
  input  wire logic                        start_in,
  input  wire logic [pfac_pkg::DIV_W-1:0]  dividend_in,
  input  wire logic [pfac_pkg::DIV_W-1:0]  divisor_in,
  output logic                             done_out,
  output logic      [pfac_pkg::DIV_W-1:0]  quot_out
);
  import pfac_pkg::*;

  // whole divider state
  typedef struct packed {
    logic              busy;   // division running
    logic [4:0]        cnt;    // bits left
    logic [DIV_W:0]    rem;    // partial remainder
    logic [DIV_W-1:0]  quo;    // shifting quotient
    logic [DIV_W-1:0]  dvs;    // held divisor
    logic              done;   // one-cycle finish pulse
  } pfac_div_s;

  pfac_div_s cur_ff;
  pfac_div_s nxt_cur;
  logic [DIV_W:0] trial;       // remainder after shift-in

  // next-state logic
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    trial = {cur_ff.rem[DIV_W-1:0], cur_ff.quo[DIV_W-1]};
    if (start_in) begin
      nxt_cur.busy = 1'b1;
      nxt_cur.cnt  = 5'd16;
      nxt_cur.rem  = '0;
      nxt_cur.quo  = dividend_in;
      nxt_cur.dvs  = divisor_in;
    end else if (cur_ff.busy) begin
      // zero divisor: saturate instead of running
      if (cur_ff.dvs == '0) begin
        nxt_cur.quo  = DIV_ZERO_RESULT;
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
      end else begin
        if (trial >= {1'b0, cur_ff.dvs}) begin
          nxt_cur.rem = trial - {1'b0, cur_ff.dvs};
          nxt_cur.quo = {cur_ff.quo[DIV_W-2:0], 1'b1};
        end else begin
          nxt_cur.rem = trial;
          nxt_cur.quo = {cur_ff.quo[DIV_W-2:0], 1'b0};
        end
        nxt_cur.cnt = cur_ff.cnt - 5'd1;
        if (cur_ff.cnt == 5'd1) begin
          nxt_cur.busy = 1'b0;
          nxt_cur.done = 1'b1;
        end
      end
    end
  end

  // state register, frozen while ce_in is low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur_ff <= '0;
    end else if (ce_in) begin
      cur_ff <= nxt_cur;
    end
  end

  assign done_out = cur_ff.done;
  assign quot_out = cur_ff.quo;
endmodule : pfac_div
`default_nettype wire

// >>> logic/pfac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - fault after count-field plus one violations
// - crowbar bit enables low-side switch on overvoltage
// - temperature equals raw over scale plus offset
// - mask is seven bytes, status order
// - mask zero lets status bit alert
// - bit 55 gates phase init failure
// - bit 54 gates group bus error
// - aux undervoltage warning at 110 percent
// - aux overvoltage warning at 95 percent
// - bit 51 gates switching period fault
// - bit 50 gates group rail fault
// - bits 49, 48 gate aux faults
// - bit 39 gates invalid command alert
module pfac_top (
  input  wire logic                          clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          ce_in,
  // command port from the management bus link layer
  input  wire logic                          cmd_valid_in,
  input  wire logic                          cmd_write_in,
  input  wire logic [7:0]                    cmd_code_in,
  input  wire logic [3:0]                    cmd_len_in,
  input  wire logic [pfac_pkg::MASK_W-1:0]   cmd_wdata_in,
  output logic                               rsp_valid_out,
  output logic                               rsp_error_out,
  output logic [pfac_pkg::MASK_W-1:0]        rsp_rdata_out,
  // output voltage limit comparator samples
  input  wire logic                          vout_sample_valid_in,
  input  wire logic                          vout_ov_viol_in,
  input  wire logic                          vout_uv_viol_in,
  output logic                               vout_ov_fault_out,
  output logic                               vout_uv_fault_out,
  output logic                               crowbar_on_out,
  // external temperature path
  input  wire logic                          ext_temp_valid_in,
  input  wire logic [15:0]                   ext_temp_raw_in,
  output logic [15:0]                        ext_temp_readback_out,
  // aux voltage monitor
  input  wire logic [15:0]                   aux_voltage_monitor_in,
  input  wire logic [15:0]                   aux_uv_fault_limit_in,
  input  wire logic [15:0]                   aux_ov_fault_limit_in,
  // status bytes from the rest of the device and fault clear
  input  wire logic [pfac_pkg::MASK_W-1:0]   status_in,
  input  wire logic                          clear_faults_in,
  output logic                               alert_output_out
);
  import pfac_pkg::*;

  // whole block state
  typedef struct packed {
    logic [7:0]        qualify;     // fault qualify config
    logic [15:0]       scale;       // temp scale constant
    logic [15:0]       offset;      // temp offset constant
    logic [MASK_W-1:0] mask;        // alert trigger mask
    logic [3:0]        ov_cnt;      // consecutive ov violations
    logic [3:0]        uv_cnt;      // consecutive uv violations
    logic              ov_fault;    // qualified ov fault
    logic              uv_fault;    // qualified uv fault
    logic              crowbar;     // low-side switch command
    logic              bad_cmd;     // sticky invalid command
    logic              aux_uv_warn; // sticky aux uv warning
    logic              aux_ov_warn; // sticky aux ov warning
    logic              rsp_valid;   // response strobe
    logic              rsp_error;   // response refused
    logic [MASK_W-1:0] rdata;       // read data
    logic [15:0]       temp;        // temperature readback
    logic              div_start;   // launch divider
    logic [15:0]       raw_hold;    // raw sample under division
  } pfac_state_s;

  pfac_state_s cur_ff;
  pfac_state_s nxt_cur;

  logic              div_done;      // divider finished
  logic [15:0]       div_quot;      // raw / scale
  logic [MASK_W-1:0] eff_status;    // status with internal events merged
  logic [MASK_BYTES-1:0] byte_hit;  // per status byte unmasked pending
  logic [23:0]       aux_x100;      // reading times 100
  logic [23:0]       uv_x110;       // uv limit times 110
  logic [23:0]       ov_x95;        // ov limit times 95
  logic              aux_uv_now;    // uv warning condition
  logic              aux_ov_now;    // ov warning condition

  // expected byte count of a command, zero when unknown
  function automatic logic [3:0] cmd_len(input logic [7:0] code);
    case (code)
      CMD_VOUT_FAULT_QUALIFY: cmd_len = LEN_BYTE;
      CMD_EXT_TEMP_SCALE:     cmd_len = LEN_WORD;
      CMD_EXT_TEMP_OFFSET:    cmd_len = LEN_WORD;
      CMD_ALERT_TRIGGER_MASK: cmd_len = LEN_BLOCK;
      default:                cmd_len = 4'h0;
    endcase
  endfunction : cmd_len

  // one qualify step: count unbroken violations, saturate at 15
  function automatic logic [3:0] qual_step(input logic       viol,
                                           input logic [3:0] cnt);
    if (!viol) begin
      qual_step = 4'h0;
    end else if (cnt == 4'hf) begin
      qual_step = cnt;
    end else begin
      qual_step = cnt + 4'h1;
    end
  endfunction : qual_step

  // aux monitor warning compares, in percent of each fault limit
  always_comb begin
    aux_x100   = 24'(aux_voltage_monitor_in) * 24'(PCT_FULL);
    uv_x110    = 24'(aux_uv_fault_limit_in) * 24'(PCT_UV_WARN);
    ov_x95     = 24'(aux_ov_fault_limit_in) * 24'(PCT_OV_WARN);
    aux_uv_now = aux_x100 < uv_x110;
    aux_ov_now = aux_x100 > ov_x95;
  end

  // merge internally raised events into the status image
  always_comb begin
    eff_status = status_in;
    eff_status[MBIT_AUX_UV_WARN] = status_in[MBIT_AUX_UV_WARN] | cur_ff.aux_uv_warn;
    eff_status[MBIT_AUX_OV_WARN] = status_in[MBIT_AUX_OV_WARN] | cur_ff.aux_ov_warn;
    eff_status[MBIT_BAD_CMD]     = status_in[MBIT_BAD_CMD] | cur_ff.bad_cmd;
  end

  // per status byte masking, byte 0 vout up to byte 6 mfr specific
  genvar gi;
  generate
    for (gi = 0; gi < MASK_BYTES; gi++) begin : g_mask_byte
      // status bit alerts only while its mask bit is zero
      assign byte_hit[gi] = |(eff_status[gi*8 +: 8] & ~cur_ff.mask[gi*8 +: 8]);
    end
  endgenerate
  // bits 55..48 gate phase init, group bus, aux warn, period, group rail
  // and aux faults through the same byte 6 path

  // next-state logic
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp_valid = 1'b0;
    nxt_cur.rsp_error = 1'b0;
    nxt_cur.div_start = 1'b0;

    // command handling: write, read or refuse
    if (cmd_valid_in) begin
      nxt_cur.rsp_valid = 1'b1;
      if (cmd_len(cmd_code_in) == 4'h0) begin
        nxt_cur.rsp_error = 1'b1;
        nxt_cur.bad_cmd   = 1'b1;
        nxt_cur.rdata     = '0;
      end else if (cmd_write_in) begin
        if (cmd_len_in != cmd_len(cmd_code_in)) begin
          // wrong byte count: whole write dropped
          nxt_cur.rsp_error = 1'b1;
        end else begin
          case (cmd_code_in)
            CMD_VOUT_FAULT_QUALIFY: nxt_cur.qualify = cmd_wdata_in[7:0];
            CMD_EXT_TEMP_SCALE:     nxt_cur.scale   = cmd_wdata_in[15:0];
            CMD_EXT_TEMP_OFFSET:    nxt_cur.offset  = cmd_wdata_in[15:0];
            CMD_ALERT_TRIGGER_MASK: nxt_cur.mask    = cmd_wdata_in;
            default:                nxt_cur.rsp_error = 1'b1;
          endcase
        end
      end else begin
        // read: narrow values sit in the low bytes
        case (cmd_code_in)
          CMD_VOUT_FAULT_QUALIFY: nxt_cur.rdata = MASK_W'(cur_ff.qualify);
          CMD_EXT_TEMP_SCALE:     nxt_cur.rdata = MASK_W'(cur_ff.scale);
          CMD_EXT_TEMP_OFFSET:    nxt_cur.rdata = MASK_W'(cur_ff.offset);
          CMD_ALERT_TRIGGER_MASK: nxt_cur.rdata = cur_ff.mask;
          default:                nxt_cur.rdata = '0;
        endcase
      end
    end

    // output voltage fault qualification
    if (vout_sample_valid_in) begin
      nxt_cur.ov_cnt = qual_step(vout_ov_viol_in, cur_ff.ov_cnt);
      nxt_cur.uv_cnt = qual_step(vout_uv_viol_in, cur_ff.uv_cnt);
      // this violation is the (count field + 1)th in a row
      if (vout_ov_viol_in &&
          cur_ff.ov_cnt >= cur_ff.qualify[QUAL_COUNT_LSB +: QUAL_COUNT_W]) begin
        nxt_cur.ov_fault = 1'b1;
      end
      if (vout_uv_viol_in &&
          cur_ff.uv_cnt >= cur_ff.qualify[QUAL_COUNT_LSB +: QUAL_COUNT_W]) begin
        nxt_cur.uv_fault = 1'b1;
      end
    end

    // clear of sticky faults and events; a same-cycle set wins
    if (clear_faults_in) begin
      if (!(vout_sample_valid_in && vout_ov_viol_in &&
            cur_ff.ov_cnt >= cur_ff.qualify[QUAL_COUNT_LSB +: QUAL_COUNT_W])) begin
        nxt_cur.ov_fault = 1'b0;
      end
      if (!(vout_sample_valid_in && vout_uv_viol_in &&
            cur_ff.uv_cnt >= cur_ff.qualify[QUAL_COUNT_LSB +: QUAL_COUNT_W])) begin
        nxt_cur.uv_fault = 1'b0;
      end
      if (!(cmd_valid_in && cmd_len(cmd_code_in) == 4'h0)) begin
        nxt_cur.bad_cmd = 1'b0;
      end
      nxt_cur.aux_uv_warn = aux_uv_now;
      nxt_cur.aux_ov_warn = aux_ov_now;
    end else begin
      nxt_cur.aux_uv_warn = cur_ff.aux_uv_warn | aux_uv_now;
      nxt_cur.aux_ov_warn = cur_ff.aux_ov_warn | aux_ov_now;
    end

    // crowbar follows the ov fault only when enabled
    nxt_cur.crowbar = nxt_cur.ov_fault & cur_ff.qualify[QUAL_CROWBAR_BIT];

    // temperature: start a division for each new raw sample
    if (ext_temp_valid_in) begin
      nxt_cur.div_start = 1'b1;
      nxt_cur.raw_hold  = ext_temp_raw_in;
    end
    if (div_done) begin
      nxt_cur.temp = div_quot + cur_ff.offset;
    end
  end

  // state register, frozen while ce_in is low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur_ff         <= '0;
      cur_ff.qualify <= RST_QUALIFY;
      cur_ff.scale   <= RST_SCALE;
      cur_ff.offset  <= RST_OFFSET;
      cur_ff.mask    <= RST_MASK;
    end else if (ce_in) begin
      cur_ff <= nxt_cur;
    end
  end

  // raw over scale; the divider saturates on a zero scale
  pfac_div u_div (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .ce_in       (ce_in),
    .start_in    (cur_ff.div_start),
    .dividend_in (cur_ff.raw_hold),
    .divisor_in  (cur_ff.scale),
    .done_out    (div_done),
    .quot_out    (div_quot)
  );

  // outputs
  assign rsp_valid_out         = cur_ff.rsp_valid;
  assign rsp_error_out         = cur_ff.rsp_error;
  assign rsp_rdata_out         = cur_ff.rdata;
  assign vout_ov_fault_out     = cur_ff.ov_fault;
  assign vout_uv_fault_out     = cur_ff.uv_fault;
  assign crowbar_on_out        = cur_ff.crowbar;
  assign ext_temp_readback_out = cur_ff.temp;
  assign alert_output_out      = |byte_hit;
endmodule : pfac_top
`default_nettype wire

// >>> bench/pfac_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// pin level checks of the configuration bank
module pfac_top_assertions (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        ce_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_write_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [3:0]  cmd_len_in,
  input wire logic [55:0] cmd_wdata_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_error_out,
  input wire logic [55:0] rsp_rdata_out,
  input wire logic        vout_sample_valid_in,
  input wire logic        vout_ov_viol_in,
  input wire logic        vout_ov_fault_out,
  input wire logic        crowbar_on_out,
  input wire logic [55:0] status_in,
  input wire logic        alert_output_out
);
  import pfac_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic        take;    // command taken at this edge
  logic        known;   // one of the four codes
  logic        good;    // known, and a write has the right length
  logic        trip;    // this sample completes the run
  logic [7:0]  qual_ff; // copy of the qualify byte
  logic [55:0] mask_ff; // copy of the alert mask
  logic [4:0]  run_ff;  // unbroken run of ov violations
  assign take  = cmd_valid_in && ce_in;
  assign known = cmd_code_in[7:2] == 6'h36;
  assign good  = known && (!cmd_write_in || cmd_len_in == ((cmd_code_in[0] ^ cmd_code_in[1]) ?
                 LEN_WORD : cmd_code_in[0] ? LEN_BLOCK : LEN_BYTE));
  assign trip  = vout_sample_valid_in && ce_in && vout_ov_viol_in && run_ff >= {1'b0, qual_ff[3:0]};
  // copies follow accepted writes, run counter follows samples
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      qual_ff <= RST_QUALIFY;
      mask_ff <= RST_MASK;
      run_ff  <= 5'h0;
    end else begin
      if (take && good && cmd_write_in && cmd_code_in == CMD_VOUT_FAULT_QUALIFY)
        qual_ff <= cmd_wdata_in[7:0];
      if (take && good && cmd_write_in && cmd_code_in == CMD_ALERT_TRIGGER_MASK)
        mask_ff <= cmd_wdata_in;
      if (vout_sample_valid_in && ce_in)
        run_ff <= !vout_ov_viol_in ? 5'h0 : (run_ff == 5'h1f) ? run_ff : run_ff + 5'h1;
    end
  end
  property p_refuse; take && !known |=> rsp_valid_out && rsp_error_out && rsp_rdata_out == '0; endproperty
  a_refuse: assert property (p_refuse) else $error("unknown code not refused");
  property p_accept; take && good |=> rsp_valid_out && !rsp_error_out; endproperty
  a_accept: assert property (p_accept) else $error("good command refused");
  property p_bad_len; take && known && !good |=> rsp_error_out; endproperty
  a_bad_len: assert property (p_bad_len) else $error("wrong length accepted");
  property p_mask_read; take && !cmd_write_in && cmd_code_in == CMD_ALERT_TRIGGER_MASK |=> rsp_rdata_out == mask_ff; endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read mismatch");
  property p_fault_set; trip |=> vout_ov_fault_out; endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not set");
  property p_fault_cause; $rose(vout_ov_fault_out) |-> $past(trip); endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault set early");
  property p_crowbar_only; crowbar_on_out |-> vout_ov_fault_out; endproperty
  a_crowbar_only: assert property (p_crowbar_only) else $error("crowbar without fault");
  property p_crowbar_on; vout_ov_fault_out && qual_ff[7] && $past(qual_ff[7]) |-> crowbar_on_out; endproperty
  a_crowbar_on: assert property (p_crowbar_on) else $error("crowbar missing");
  property p_alert_on; (status_in & ~mask_ff) != '0 |-> alert_output_out; endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert missing");
  property p_alert_off; alert_output_out |-> ((status_in | 56'h30_0080_0000_0000) & ~mask_ff) != '0; endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert not masked");
endmodule : pfac_top_assertions
`default_nettype wire

// >>> bench/pfac_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the command port, one whole command per call
module pfac_host (
  input  wire logic        clk_in,
  output var  logic        cmd_valid_out,
  output var  logic        cmd_write_out,
  output var  logic [7:0]  cmd_code_out,
  output var  logic [3:0]  cmd_len_out,
  output var  logic [55:0] cmd_wdata_out,
  input  wire logic        rsp_error_in,
  input  wire logic [55:0] rsp_rdata_in
);
  import pfac_pkg::*;
  logic        err = 1'b0; // error flag of the last answer
  logic [55:0] rdata = '0; // data of the last answer
  // idle bus at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out  = 8'h00;
    cmd_len_out   = 4'h0;
    cmd_wdata_out = '0;
  end
  // drive after an edge, hold through the taking edge, then pick up the answer
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [3:0] len,
                      input logic [55:0] data);
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_write_out = wr;
    cmd_code_out  = code;
    cmd_len_out   = len;
    cmd_wdata_out = data;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_wdata_out = ~data; // released data keeps no stale value
    err           = rsp_error_in;
    rdata         = rsp_rdata_in;
  endtask : xfer
endmodule : pfac_host
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pfac_pkg::*;
  // one alert case: mask written, status driven, alert expected
  typedef struct packed {logic [55:0] mask; logic [55:0] stat; logic alert;} pfac_row_s;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        cmd_valid, cmd_write, rsp_error, alert, crowbar, ov_flt, uv_flt;
  logic [7:0]  cmd_code;
  logic [3:0]  cmd_len;
  logic [55:0] cmd_wdata, rsp_rdata, full;
  logic        smp = 1'b0, ov_v = 1'b0, uv_v = 1'b0, clr = 1'b0, t_valid = 1'b0, ce = 1'b1;
  logic [15:0] t_raw = 16'h0064, t_rb;
  logic [15:0] aux = 16'h00c8, uv_lim = 16'h0064, ov_lim = 16'hffff;
  logic [55:0] status = '0;
  int          num_errors = 0, checked = 0;
  pfac_row_s rows [9] = '{
    '{56'h0, 56'h0001, 1'b1},
    '{56'h0001, 56'h0001, 1'b0},
    '{56'h0100, 56'h0001, 1'b1},
    '{56'h80_0000_0000_0000, 56'h80_0000_0000_0000, 1'b0},
    '{56'h40_0000_0000_0000, 56'hc0_0000_0000_0000, 1'b1},
    '{56'h0c_0000_0000_0000, 56'h0c_0000_0000_0000, 1'b0},
    '{56'h03_0000_0000_0000, 56'h07_0000_0000_0000, 1'b1},
    '{56'h03_0000_0000_0000, 56'h03_0000_0000_0000, 1'b0},
    '{56'h00_0080_0000_0000, 56'h00_0080_0000_0000, 1'b0}
  };
  pfac_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_code_in(cmd_code), .cmd_len_in(cmd_len),
    .cmd_wdata_in(cmd_wdata), .rsp_valid_out(), .rsp_error_out(rsp_error),
    .rsp_rdata_out(rsp_rdata), .vout_sample_valid_in(smp), .vout_ov_viol_in(ov_v),
    .vout_uv_viol_in(uv_v), .vout_ov_fault_out(ov_flt), .vout_uv_fault_out(uv_flt),
    .crowbar_on_out(crowbar), .ext_temp_valid_in(t_valid), .ext_temp_raw_in(t_raw),
    .ext_temp_readback_out(t_rb), .aux_voltage_monitor_in(aux), .aux_uv_fault_limit_in(uv_lim),
    .aux_ov_fault_limit_in(ov_lim), .status_in(status), .clear_faults_in(clr),
    .alert_output_out(alert));
  pfac_host u_host (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
    .cmd_code_out(cmd_code), .cmd_len_out(cmd_len), .cmd_wdata_out(cmd_wdata),
    .rsp_error_in(rsp_error), .rsp_rdata_in(rsp_rdata));
  // 50 MHz clock
  initial forever #10 clk_in = ~clk_in;
  task automatic check(input logic [55:0] got, input logic [55:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // n edges, then settle just after the last one
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cycles
  // comparator samples back to back, bit i is sample i
  task automatic samples(input int n, input logic [7:0] ov, input logic [7:0] uv);
    for (int i = 0; i < n; i++) begin
      smp = 1'b1;
      ov_v = ov[i];
      uv_v = uv[i];
      cycles(1);
    end
    smp = 1'b0;
    cycles(1);
  endtask : samples
  task automatic clear_faults;
    clr = 1'b1;
    cycles(1);
    clr = 1'b0;
  endtask : clear_faults
  // one raw sample, then wait out the divider
  task automatic temp_check(input logic [15:0] exp);
    t_valid = 1'b1;
    cycles(1);
    t_valid = 1'b0;
    cycles(20);
    check(56'(t_rb), 56'(exp), "temperature readback");
  endtask : temp_check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // cut a hang short
  initial begin
    #(20 * 5000);
    num_errors++;
    end_sim;
  end
  initial begin
    cycles(16);
    reset_n_in = 1'b1;
    // reset values, then each register written full and read back
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b0, CMD_VOUT_FAULT_QUALIFY + 8'(i), 4'h0, '0);
      check(u_host.rdata, (i == 1) ? 56'h0001 : 56'h0, "reset value");
      full = (i == 0) ? 56'h00ff : (i == 3) ? '1 : 56'hffff;
      u_host.xfer(1'b1, CMD_VOUT_FAULT_QUALIFY + 8'(i),
                  (i == 0) ? LEN_BYTE : (i == 3) ? LEN_BLOCK : LEN_WORD, full);
      u_host.xfer(1'b0, CMD_VOUT_FAULT_QUALIFY + 8'(i), 4'h0, '0);
      check(u_host.rdata, full, "register readback");
    end
    // clock enable low: the write is not taken and the offset holds
    ce = 1'b0;
    u_host.xfer(1'b1, CMD_EXT_TEMP_OFFSET, LEN_WORD, 56'h1234);
    ce = 1'b1;
    u_host.xfer(1'b0, CMD_EXT_TEMP_OFFSET, 4'h0, '0);
    check(u_host.rdata, 56'hffff, "frozen while disabled");
    foreach (rows[i]) begin
      u_host.xfer(1'b1, CMD_ALERT_TRIGGER_MASK, LEN_BLOCK, rows[i].mask);
      status = rows[i].stat;
      cycles(1);
      check(56'(alert), 56'(rows[i].alert), "alert gating");
    end
    status = '0;
    // unknown code raises the invalid command event
    u_host.xfer(1'b1, CMD_ALERT_TRIGGER_MASK, LEN_BLOCK, '0);
    u_host.xfer(1'b0, 8'hd7, 4'h0, '0);
    check(56'(u_host.err), 56'h1, "unknown code");
    cycles(1);
    check(56'(alert), 56'h1, "invalid command alert");
    u_host.xfer(1'b1, CMD_ALERT_TRIGGER_MASK, LEN_BLOCK, 56'h00_0080_0000_0000);
    check(56'(alert), 56'h0, "invalid command masked");
    clear_faults;
    // mask sent short: refused, nothing stored, no event
    u_host.xfer(1'b1, CMD_ALERT_TRIGGER_MASK, LEN_WORD, 56'hffff);
    check(56'(u_host.err), 56'h1, "short mask write");
    check(56'(alert), 56'h0, "event cleared, mask kept");
    u_host.xfer(1'b0, CMD_ALERT_TRIGGER_MASK, 4'h0, '0);
    check(u_host.rdata, 56'h00_0080_0000_0000, "short write stored nothing");
    // aux monitor warnings at and past their limits
    u_host.xfer(1'b1, CMD_ALERT_TRIGGER_MASK, LEN_BLOCK, 56'hcf_ffff_ffff_ffff);
    aux = 16'h006e;
    cycles(3);
    check(56'(alert), 56'h0, "uv warning at limit");
    aux = 16'h006d;
    cycles(3);
    check(56'(alert), 56'h1, "uv warning below limit");
    aux = 16'h00c8;
    clear_faults;
    uv_lim = 16'h0000;
    ov_lim = 16'h0064;
    aux = 16'h005f;
    cycles(3);
    check(56'(alert), 56'h0, "ov warning at limit");
    aux = 16'h0060;
    cycles(3);
    check(56'(alert), 56'h1, "ov warning above limit");
    // fault qualification, broken run first, then crowbar on and off
    u_host.xfer(1'b1, CMD_VOUT_FAULT_QUALIFY, LEN_BYTE, 56'h0082);
    samples(5, 8'h1b, 8'h00);
    check(56'(ov_flt), 56'h0, "broken run");
    samples(1, 8'h01, 8'h00);
    check(56'({ov_flt, crowbar}), 56'h3, "third violation");
    u_host.xfer(1'b1, CMD_VOUT_FAULT_QUALIFY, LEN_BYTE, 56'h0002);
    clear_faults;
    samples(4, 8'h0e, 8'h00);
    check(56'({ov_flt, crowbar}), 56'h2, "fault without crowbar");
    u_host.xfer(1'b1, CMD_VOUT_FAULT_QUALIFY, LEN_BYTE, 56'h0000);
    samples(1, 8'h00, 8'h01);
    check(56'(uv_flt), 56'h1, "single uv violation");
    // 100 / 7 + 16, then zero scale with wrapping offset
    u_host.xfer(1'b1, CMD_EXT_TEMP_SCALE, LEN_WORD, 56'h0007);
    u_host.xfer(1'b1, CMD_EXT_TEMP_OFFSET, LEN_WORD, 56'h0010);
    temp_check(16'h001e);
    u_host.xfer(1'b1, CMD_EXT_TEMP_SCALE, LEN_WORD, 56'h0000);
    temp_check(16'h000f);
    end_sim;
  end
endmodule : tb_top
bind pfac_top pfac_top_assertions u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
  .cmd_code_in(cmd_code_in), .cmd_len_in(cmd_len_in), .cmd_wdata_in(cmd_wdata_in),
  .rsp_valid_out(rsp_valid_out), .rsp_error_out(rsp_error_out), .rsp_rdata_out(rsp_rdata_out),
  .vout_sample_valid_in(vout_sample_valid_in), .vout_ov_viol_in(vout_ov_viol_in),
  .vout_ov_fault_out(vout_ov_fault_out), .crowbar_on_out(crowbar_on_out),
  .status_in(status_in), .alert_output_out(alert_output_out));
`default_nettype wire
